// [tb/phs_pin_model.sv]
`timescale 1ns/10ps
module phs_pin_model (
    input  wire logic       pclk,
    input  wire logic [7:0] p1_out,
    input  wire logic [7:0] p1_oe_n,
    input  wire logic [7:0] p1_weak_pullup,
    input  wire logic [7:0] ext_low,
    input  wire logic       cmp_pin4_out,
    input  wire logic       cmp_pin4_oe_n,
    input  wire logic       cmp_pin5_out,
    input  wire logic       cmp_pin5_oe_n,
    input  wire logic [1:0] ext_cap,
    output logic [7:0]      p1_in,
    output logic            cap_pin2_in,
    output logic            cap_pin3_in,
    output logic            cap_in0,
    output logic            cap_in1
);
    // weak high yields to load
    // Floating bit without pull-up shows inverse of last drive
    assign p1_in = (~p1_oe_n & p1_out) | (p1_oe_n & ~ext_low & (p1_weak_pullup | ~p1_out));
    assign cap_pin2_in = cmp_pin4_oe_n ? ext_cap[0] : cmp_pin4_out;
    assign cap_pin3_in = cmp_pin5_oe_n ? ext_cap[1] : cmp_pin5_out;
    initial begin
        cap_in0 = 1'b0;
        cap_in1 = 1'b0;
    end
    task automatic pulse(input int which);
        @(posedge pclk);
        if (which == 0) cap_in0 <= 1'b1;
        else cap_in1 <= 1'b1;
        repeat (2) @(posedge pclk);
        cap_in0 <= 1'b0;
        cap_in1 <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : pulse
endmodule : phs_pin_model

// [tb/phs_port_one_sva.sv]
`timescale 1ns/10ps
module phs_port_one_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  p1_oe_n,
    input wire logic [7:0]  p1_weak_pullup,
    input wire logic        cap_in0,
    input wire logic        cap_in1,
    input wire logic [5:0]  cmp_val,
    input wire logic        cmp_pin0,
    input wire logic        cmp_pin1,
    input wire logic        cmp_pin4_out,
    input wire logic        cmp_pin4_oe_n,
    input wire logic [3:0]  cap_event,
    input wire logic        t2_reset,
    input wire logic        t2_ext_tick
);
    logic [7:0] c0, c1, c3, pd;
    wire        wr = psel && penable && pready && pwrite && paddr[1:0] == 2'b00;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // Shadow of control state seen on the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {c0, c1, c3} <= 24'h00_0000;
            pd <= 8'hff;
        end else if (wr) begin
            case (paddr[11:2])
                phs_pkg::IDX_IO_CTRL0: c0 <= pwdata[7:0];
                phs_pkg::IDX_IO_CTRL1: c1 <= pwdata[7:0];
                phs_pkg::IDX_IO_CTRL3: c3 <= pwdata[7:0];
                phs_pkg::IDX_PORT_ONE: pd <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    cap_load_a: assert property ($rose(cap_in0) |=> cap_event[0] == $past(c0[0]))
        else $error("capture load does not follow enable");
    t2_reset_a: assert property ($rose(cap_in0) |=> t2_reset == $past(c0[3] && c0[5]))
        else $error("timer reset does not follow enables");
    t2_tick_a: assert property ($rose(cap_in1) |=> t2_ext_tick == $past(c0[7] && !c3[0]))
        else $error("external tick does not follow select");
    cmp_fixed_a: assert property ($past(presetn) |-> {cmp_pin1, cmp_pin0} == $past(cmp_val[1:0]))
        else $error("dedicated compare pins wrong");
    cmp_drive_a: assert property ($past(presetn) |-> cmp_pin4_oe_n == !$past(c1[4])
        && cmp_pin4_out == $past(cmp_val[4])) else $error("compare pin 4 drive wrong");
    port_quasi_a: assert property ($past(presetn) |-> p1_oe_n[2:0] == $past(pd[2:0])
        && p1_weak_pullup[2:0] == $past(pd[2:0])) else $error("quasi port drive wrong");
    pwm_pin_a: assert property ($past(presetn) && $past(c3[2]) |-> !p1_oe_n[3] && !p1_weak_pullup[3])
        else $error("pulse-width pin not strongly driven");
    cover property (cap_event[0]);
    cover property (t2_reset);
    cover property (t2_ext_tick);
    cover property (pslverr);
endmodule : phs_port_one_sva

bind phs_port_one phs_port_one_sva sva_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pready, .pslverr, .p1_oe_n, .p1_weak_pullup, .cap_in0, .cap_in1, .cmp_val, .cmp_pin0, .cmp_pin1,
    .cmp_pin4_out, .cmp_pin4_oe_n, .cap_event, .t2_reset, .t2_ext_tick);

// [tb/test_port1_hsio_pin_function_select.sv]
`timescale 1ns/10ps
module test_port1_hsio_pin_function_select;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, clr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0]  p1_in, p1_out, p1_oe_n, p1_weak_pullup, ext_low;
    logic        cap_in0, cap_in1, cap_pin2_in, cap_pin3_in, cmp_pin0, cmp_pin1, irq;
    logic        cmp_pin4_out, cmp_pin4_oe_n, cmp_pin5_out, cmp_pin5_oe_n, t2_reset, t2_ext_tick, t2_ext_clk_sel;
    logic [5:0]  cmp_val;
    logic [3:0]  cap_event, seen_ev;
    logic [1:0]  ext_cap, seen_t2;
    int          n_errors, compares, cyc, hi3, hi4, up4;

    phs_port_one dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .p1_in, .p1_out, .p1_oe_n, .p1_weak_pullup, .cap_in0, .cap_in1, .cap_pin2_in,
        .cap_pin3_in, .cmp_val, .cmp_pin0, .cmp_pin1, .cmp_pin4_out, .cmp_pin4_oe_n, .cmp_pin5_out,
        .cmp_pin5_oe_n, .cap_event, .t2_reset, .t2_ext_tick, .t2_ext_clk_sel, .irq);
    phs_pin_model model_u (.pclk, .p1_out, .p1_oe_n, .p1_weak_pullup, .ext_low, .cmp_pin4_out,
        .cmp_pin4_oe_n, .cmp_pin5_out, .cmp_pin5_oe_n, .ext_cap, .p1_in, .cap_pin2_in, .cap_pin3_in,
        .cap_in0, .cap_in1);

    always #5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////
    // Sticky record of one-cycle pulses, so checks need not race them
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        seen_ev <= clr ? 4'h0 : seen_ev | cap_event;
        seen_t2 <= clr ? 2'b00 : seen_t2 | {t2_ext_tick, t2_reset};
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            report_and_stop;
        end
    end

    task report_and_stop;
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Waits on pready alone; only the cycle ceiling ends a hang
    task apb(input logic [9:0] idx, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= {idx, 2'b00};
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task fire(input int which);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        @(posedge pclk);
        if (which >= 0) model_u.pulse(which);
    endtask : fire

    task measure;
        logic prev;
        hi3 = 0;
        hi4 = 0;
        up4 = 0;
        prev = p1_in[4];
        repeat (512) begin
            @(posedge pclk);
            hi3 += p1_in[3];
            hi4 += p1_in[4];
            up4 += (p1_in[4] && !prev);
            prev = p1_in[4];
        end
    endtask : measure
    ////////////////////////////////////////////////////////////////
    task s_regs;
        apb(phs_pkg::IDX_INT_VECTOR, 1'b0, 32'h0000_0000);
        check(rdv, 32'h0000_2008);
        apb(phs_pkg::IDX_PORT_ONE, 1'b0, 32'h0000_0000);
        check(rdv, 32'h0000_00ff);
        apb(10'h00a, 1'b0, 32'h0000_0000);
        check({rdv[31:1], err}, 32'h0000_0001);
        apb(phs_pkg::IDX_INT_STATUS, 1'b1, 32'h0000_003f);
        apb(phs_pkg::IDX_INT_STATUS, 1'b0, 32'h0000_0000);
        check(rdv, 32'h0000_0000);
        apb(phs_pkg::IDX_IO_CTRL2, 1'b1, 32'h0000_ffa5);
        apb(phs_pkg::IDX_IO_CTRL2, 1'b0, 32'h0000_0000);
        check(rdv, 32'h0000_00a5);
        apb(phs_pkg::IDX_IO_CTRL2, 1'b1, 32'h0000_0000);
    endtask : s_regs

    task s_port;
        ext_low <= 8'h02;
        apb(phs_pkg::IDX_PORT_ONE, 1'b1, 32'h0000_005a);
        repeat (3) @(posedge pclk);
        check({p1_oe_n, p1_weak_pullup, p1_out & 8'ha5}, 32'h005a_5a00);
        apb(phs_pkg::IDX_PORT_ONE, 1'b0, 32'h0000_0000);
        check(rdv, 32'h0000_0058);
        ext_low <= 8'h00;
    endtask : s_port

    task s_pwm;
        apb(phs_pkg::IDX_PW_ONE_DUTY, 1'b1, 32'h0000_0080);
        apb(phs_pkg::IDX_PW_TWO_DUTY, 1'b1, 32'h0000_0040);
        apb(phs_pkg::IDX_IO_CTRL3, 1'b1, 32'h0000_000c);
        repeat (600) @(posedge pclk);
        measure;
        check(hi3, 256);
        check(hi4, 128);
        check(up4, 2);
        apb(phs_pkg::IDX_IO_CTRL2, 1'b1, 32'h0000_0004);
        repeat (600) @(posedge pclk);
        measure;
        check(hi3, 256);
        check(hi4, 128);
        check(up4, 1);
        apb(phs_pkg::IDX_IO_CTRL3, 1'b1, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        check(p1_oe_n, 8'h5a);
    endtask : s_pwm

    task s_cap;
        apb(phs_pkg::IDX_INT_ENABLE, 1'b1, 32'h0000_003f);
        apb(phs_pkg::IDX_IO_CTRL0, 1'b1, 32'h0000_0001);
        fire(0);
        check(seen_ev, 4'h1);
        apb(phs_pkg::IDX_INT_STATUS, 1'b0, 32'h0000_0000);
        check(rdv, 32'h0000_0003);
        check(irq, 32'h0000_0001);
        apb(phs_pkg::IDX_INT_CLEAR, 1'b1, 32'h0000_003f);
        apb(phs_pkg::IDX_INT_STATUS, 1'b0, 32'h0000_0000);
        check(rdv, 32'h0000_0000);
        check(irq, 32'h0000_0000);
        apb(phs_pkg::IDX_IO_CTRL0, 1'b1, 32'h0000_0028);
        apb(phs_pkg::IDX_INT_ENABLE, 1'b1, 32'h0000_0000);
        fire(0);
        check({seen_ev, seen_t2}, 6'h01);
        apb(phs_pkg::IDX_INT_STATUS, 1'b0, 32'h0000_0000);
        check(rdv, 32'h0000_0021);
        check(irq, 32'h0000_0000);
        apb(phs_pkg::IDX_INT_CLEAR, 1'b1, 32'h0000_003f);
    endtask : s_cap

    task s_timer_two_clock_pin;
        apb(phs_pkg::IDX_IO_CTRL0, 1'b1, 32'h0000_0084);
        fire(1);
        check({seen_ev, seen_t2, t2_ext_clk_sel}, 7'b0010_101);
        apb(phs_pkg::IDX_IO_CTRL3, 1'b1, 32'h0000_0001);
        fire(1);
        check({seen_t2, t2_ext_clk_sel}, 3'b000);
    endtask : s_timer_two_clock_pin

    task s_cmp;
        apb(phs_pkg::IDX_IO_CTRL1, 1'b1, 32'h0000_0050);
        apb(phs_pkg::IDX_IO_CTRL0, 1'b1, 32'h0000_0050);
        fire(-1);
        cmp_val <= 6'h13;
        repeat (4) @(posedge pclk);
        check(seen_ev, 4'h4);
        check({cmp_pin4_oe_n, cmp_pin4_out, cmp_pin5_oe_n, cmp_pin1, cmp_pin0}, 5'b01011);
        cmp_val <= 6'h33;
        repeat (4) @(posedge pclk);
        check({seen_ev, cmp_pin5_out}, 5'h19);
        apb(phs_pkg::IDX_IO_CTRL1, 1'b1, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        check({cmp_pin4_oe_n, cmp_pin5_oe_n}, 2'b11);
    endtask : s_cmp
    ////////////////////////////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, cmp_val} = '0;
        {ext_low, ext_cap, n_errors, compares, cyc} = '0;
        clr = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        clr <= 1'b0;
        s_regs;
        s_port;
        s_pwm;
        s_cap;
        s_timer_two_clock_pin;
        s_cmp;
        report_and_stop;
    end
endmodule : test_port1_hsio_pin_function_select

// [verilog/phs_edge.sv]
`timescale 1ns/10ps
module phs_edge #(
    parameter int W = 4
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] level,
    output logic [W-1:0]      rise
);
    logic [W-1:0] prev;

    // Reset value low: a pin already high at release counts as an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= '0;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
endmodule : phs_edge

// [verilog/phs_pkg.sv]
package phs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_IO_CTRL0    = 10'h000;
    localparam logic [9:0] IDX_IO_CTRL1    = 10'h001;
    localparam logic [9:0] IDX_IO_CTRL2    = 10'h002;
    localparam logic [9:0] IDX_IO_CTRL3    = 10'h003;
    localparam logic [9:0] IDX_PW_ONE_DUTY = 10'h004;
    localparam logic [9:0] IDX_PW_TWO_DUTY = 10'h005;
    localparam logic [9:0] IDX_INT_STATUS  = 10'h006;
    localparam logic [9:0] IDX_INT_ENABLE  = 10'h007;
    localparam logic [9:0] IDX_INT_CLEAR   = 10'h008;
    localparam logic [9:0] IDX_INT_VECTOR  = 10'h009;
    localparam logic [9:0] IDX_PORT_ONE    = 10'h00f;

    localparam logic [7:0]  RST_PORT_ONE   = 8'hff;
    localparam logic [7:0]  RST_IO_CTRL    = 8'h00;
    localparam logic [7:0]  RST_DUTY       = 8'h00;
    localparam logic [5:0]  RST_INT        = 6'h00;
    localparam logic [15:0] CAP_PIN_VECTOR = 16'h2008;

    // io_ctrl0 fields
    localparam int C0_CAP0_EN  = 0;
    localparam int C0_CAP1_EN  = 2;
    localparam int C0_T2_RST_A  = 3;
    localparam int C0_CAP2_EN  = 4;
    localparam int C0_T2_RST_B  = 5;
    localparam int C0_CAP3_EN  = 6;
    localparam int C0_T2_CLK_EN = 7;
    // io_ctrl1 fields
    localparam int C1_CMP4_EN  = 4;
    localparam int C1_CMP5_EN  = 6;
    // io_ctrl2 fields
    localparam int C2_PWM_FREQ = 2;
    // io_ctrl3 fields
    localparam int C3_T2_CLK_INT = 0;
    localparam int C3_PW_ONE_SEL = 2;
    localparam int C3_PW_TWO_SEL = 3;

    // Interrupt status layout
    localparam int IS_CAP_PIN  = 0;
    localparam int IS_CAP_EVT0 = 1;
    localparam int IS_T2_RST   = 5;

    // Port bit positions of the shared pins
    localparam int P1_PW_ONE_BIT = 3;
    localparam int P1_PW_TWO_BIT = 4;

    // Pulse-width period divider: 1 normal, 2 slow
    localparam logic [1:0] PWM_DIV_FAST = 2'h1;
    localparam logic [1:0] PWM_DIV_SLOW = 2'h2;
endpackage : phs_pkg

// [verilog/phs_port_one.sv]
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module phs_port_one #(
    parameter int DW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic [11:0]   paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Port-one pins
    input  wire logic [DW-1:0] p1_in,
    output logic [DW-1:0]      p1_out,
    output logic [DW-1:0]      p1_oe_n,
    output logic [DW-1:0]      p1_weak_pullup,
    // Capture and timer-two pins
    input  wire logic          cap_in0,
    input  wire logic          cap_in1,
    input  wire logic          cap_pin2_in,
    input  wire logic          cap_pin3_in,
    // Compare unit values and pins
    input  wire logic [5:0]    cmp_val,
    output logic               cmp_pin0,
    output logic               cmp_pin1,
    output logic               cmp_pin4_out,
    output logic               cmp_pin4_oe_n,
    output logic               cmp_pin5_out,
    output logic               cmp_pin5_oe_n,
    // Toward the capture unit, timer two and the interrupt request
    output logic [3:0]         cap_event,
    output logic               t2_reset,
    output logic               t2_ext_tick,
    output logic               t2_ext_clk_sel,
    output logic               irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [DW-1:0] port_one_pin_data;
    logic [7:0]    io_ctrl0;
    logic [7:0]    io_ctrl1;
    logic [7:0]    io_ctrl2;
    logic [7:0]    io_ctrl3;
    logic [7:0]    pw_one_duty;
    logic [7:0]    pw_two_duty;
    logic [5:0]    int_status;
    logic [5:0]    int_enable;

    logic          acc;
    logic          wr_done;
    logic          wr_ok;
    logic [9:0]    idx;
    logic          mapped;
    logic [31:0]   next_prdata;

    assign acc     = psel && penable;
    assign wr_done = acc && pready && pwrite;
    assign wr_ok   = wr_done && mapped;
    assign idx     = paddr[11:2];

    function automatic logic is_mapped(input logic [9:0] i);
        unique case (i)
            phs_pkg::IDX_IO_CTRL0, phs_pkg::IDX_IO_CTRL1,
            phs_pkg::IDX_IO_CTRL2, phs_pkg::IDX_IO_CTRL3,
            phs_pkg::IDX_PW_ONE_DUTY, phs_pkg::IDX_PW_TWO_DUTY,
            phs_pkg::IDX_INT_STATUS, phs_pkg::IDX_INT_ENABLE,
            phs_pkg::IDX_INT_CLEAR, phs_pkg::IDX_INT_VECTOR,
            phs_pkg::IDX_PORT_ONE: is_mapped = 1'b1;
            default:               is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    function automatic logic wr_hit(input logic go, input logic [9:0] at, input logic [9:0] want);
        wr_hit = go && (at == want);
    endfunction : wr_hit

    assign mapped = is_mapped(idx) && (paddr[1:0] == 2'b00);

    ////////////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state so read data comes from a flop
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (idx)
            phs_pkg::IDX_IO_CTRL0:   next_prdata[7:0]  = io_ctrl0;
            phs_pkg::IDX_IO_CTRL1:   next_prdata[7:0]  = io_ctrl1;
            phs_pkg::IDX_IO_CTRL2:   next_prdata[7:0]  = io_ctrl2;
            phs_pkg::IDX_IO_CTRL3:   next_prdata[7:0]  = io_ctrl3;
            phs_pkg::IDX_PW_ONE_DUTY: next_prdata[7:0] = pw_one_duty;
            phs_pkg::IDX_PW_TWO_DUTY: next_prdata[7:0] = pw_two_duty;
            phs_pkg::IDX_INT_STATUS: next_prdata[5:0]  = int_status;
            phs_pkg::IDX_INT_ENABLE: next_prdata[5:0]  = int_enable;
            phs_pkg::IDX_INT_VECTOR: next_prdata[15:0] = phs_pkg::CAP_PIN_VECTOR;
            phs_pkg::IDX_PORT_ONE:   next_prdata[DW-1:0] = p1_in;
            default:                 next_prdata = 32'h0000_0000;
        endcase
        if (!mapped) begin
            next_prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc && !pready;
            pslverr <= acc && !pready && !mapped;
            if (acc && !pready && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Writable registers
    // port data store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_one_pin_data <= phs_pkg::RST_PORT_ONE;
        end else if (wr_hit(wr_ok, idx, phs_pkg::IDX_PORT_ONE)) begin
            port_one_pin_data <= pwdata[DW-1:0];
        end
    end

    // One process per register; read-only and write-only indices store nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_ctrl0 <= phs_pkg::RST_IO_CTRL;
        end else if (wr_hit(wr_ok, idx, phs_pkg::IDX_IO_CTRL0)) begin
            io_ctrl0 <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_ctrl1 <= phs_pkg::RST_IO_CTRL;
        end else if (wr_hit(wr_ok, idx, phs_pkg::IDX_IO_CTRL1)) begin
            io_ctrl1 <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_ctrl2 <= phs_pkg::RST_IO_CTRL;
        end else if (wr_hit(wr_ok, idx, phs_pkg::IDX_IO_CTRL2)) begin
            io_ctrl2 <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_ctrl3 <= phs_pkg::RST_IO_CTRL;
        end else if (wr_hit(wr_ok, idx, phs_pkg::IDX_IO_CTRL3)) begin
            io_ctrl3 <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_one_duty <= phs_pkg::RST_DUTY;
        end else if (wr_hit(wr_ok, idx, phs_pkg::IDX_PW_ONE_DUTY)) begin
            pw_one_duty <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_two_duty <= phs_pkg::RST_DUTY;
        end else if (wr_hit(wr_ok, idx, phs_pkg::IDX_PW_TWO_DUTY)) begin
            pw_two_duty <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_enable <= phs_pkg::RST_INT;
        end else if (wr_hit(wr_ok, idx, phs_pkg::IDX_INT_ENABLE)) begin
            int_enable <= pwdata[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse-width outputs
    logic [1:0] div_cnt;
    logic [1:0] div_top;
    logic       pwm_tick;
    logic       pw_one_wave;
    logic       pw_two_wave;

    assign div_top = io_ctrl2[phs_pkg::C2_PWM_FREQ] ? phs_pkg::PWM_DIV_SLOW : phs_pkg::PWM_DIV_FAST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt  <= 2'h0;
            pwm_tick <= 1'b0;
        end else if (div_cnt + 2'h1 >= div_top) begin
            div_cnt  <= 2'h0;
            pwm_tick <= 1'b1;
        end else begin
            div_cnt  <= div_cnt + 2'h1;
            pwm_tick <= 1'b0;
        end
    end

    phs_pwm #(.W(8)) u_pw_one (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (pwm_tick),
        .duty    (pw_one_duty),
        .pwm_out (pw_one_wave)
    );

    phs_pwm #(.W(8)) u_pw_two (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (pwm_tick),
        .duty    (pw_two_duty),
        .pwm_out (pw_two_wave)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Port-one pin drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p1_out         <= '0;
            p1_oe_n        <= '1;
            p1_weak_pullup <= '1;
        end else begin
            for (int b = 0; b < DW; b++) begin
                p1_out[b]         <= 1'b0;
                p1_oe_n[b]        <= port_one_pin_data[b];
                p1_weak_pullup[b] <= port_one_pin_data[b];
            end
            if (io_ctrl3[phs_pkg::C3_PW_ONE_SEL]) begin
                p1_out[phs_pkg::P1_PW_ONE_BIT]         <= pw_one_wave;
                p1_oe_n[phs_pkg::P1_PW_ONE_BIT]        <= 1'b0;
                p1_weak_pullup[phs_pkg::P1_PW_ONE_BIT] <= 1'b0;
            end
            if (io_ctrl3[phs_pkg::C3_PW_TWO_SEL]) begin
                p1_out[phs_pkg::P1_PW_TWO_BIT]         <= pw_two_wave;
                p1_oe_n[phs_pkg::P1_PW_TWO_BIT]        <= 1'b0;
                p1_weak_pullup[phs_pkg::P1_PW_TWO_BIT] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_pin0      <= 1'b0;
            cmp_pin1      <= 1'b0;
            cmp_pin4_out  <= 1'b0;
            cmp_pin4_oe_n <= 1'b1;
            cmp_pin5_out  <= 1'b0;
            cmp_pin5_oe_n <= 1'b1;
        end else begin
            cmp_pin0      <= cmp_val[0];
            cmp_pin1      <= cmp_val[1];
            cmp_pin4_out  <= cmp_val[4];
            cmp_pin4_oe_n <= !io_ctrl1[phs_pkg::C1_CMP4_EN];
            cmp_pin5_out  <= cmp_val[5];
            cmp_pin5_oe_n <= !io_ctrl1[phs_pkg::C1_CMP5_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Capture inputs, timer two and interrupts
    logic [4:0] rise;
    logic [3:0] cap_en;
    logic       t2_rst_en;
    logic       t2_clk_en;
    logic [5:0] int_set;
    logic [5:0] int_clr;

    // shared pins sample the wire, so driven compare events are seen
    phs_edge #(.W(5)) u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .level   ({cap_in1, cap_pin3_in, cap_pin2_in, cap_in1, cap_in0}),
        .rise    (rise)
    );

    assign cap_en = {io_ctrl0[phs_pkg::C0_CAP3_EN], io_ctrl0[phs_pkg::C0_CAP2_EN],
                     io_ctrl0[phs_pkg::C0_CAP1_EN], io_ctrl0[phs_pkg::C0_CAP0_EN]};
    assign t2_rst_en = io_ctrl0[phs_pkg::C0_T2_RST_A] && io_ctrl0[phs_pkg::C0_T2_RST_B];
    assign t2_clk_en = io_ctrl0[phs_pkg::C0_T2_CLK_EN] && !io_ctrl3[phs_pkg::C3_T2_CLK_INT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_event      <= 4'h0;
            t2_reset       <= 1'b0;
            t2_ext_tick    <= 1'b0;
            t2_ext_clk_sel <= 1'b0;
        end else begin
            cap_event      <= rise[3:0] & cap_en;
            t2_reset       <= rise[0] && t2_rst_en;
            t2_ext_tick    <= rise[4] && t2_clk_en;
            t2_ext_clk_sel <= t2_clk_en;
        end
    end

    // cap_in0 edge always sets status bit 0; enable gates the output
    assign int_set = {rise[0] && t2_rst_en, rise[3:0] & cap_en, rise[0]};
    assign int_clr = wr_hit(wr_ok, idx, phs_pkg::IDX_INT_CLEAR) ? pwdata[5:0] : 6'h00;

    // Set wins over clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= phs_pkg::RST_INT;
        end else begin
            int_status <= (int_status & ~int_clr) | int_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((int_status & ~int_clr) | int_set) & int_enable);
        end
    end
endmodule : phs_port_one

// [verilog/phs_pwm.sv]
`timescale 1ns/10ps
module phs_pwm #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         tick,
    input  wire logic [W-1:0] duty,
    output logic              pwm_out
);
    logic [W-1:0] cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt     <= '0;
            pwm_out <= 1'b0;
        end else if (tick) begin
            cnt     <= cnt + 1'b1;
            // Duty of zero keeps the output low all period
            pwm_out <= (cnt < duty);
        end
    end
endmodule : phs_pwm
